// >>> lsw_chan_diag.v
// One channel: filter, overload delay, fault latch and restart pattern
`timescale 1ns/1ps
`default_nettype none
`include "lsw_consts.vh"
module lsw_chan_diag #(
   parameter FILT_CYC = `LSW_FILT_CYC,
   parameter OVL_CYC = `LSW_OVL_CYC,
   parameter CW = 16
) (
   input wire core_clk_i,
   input wire rst_i,
   input wire cmd_on_i,
   input wire static_lim_i,
   input wire store_en_i,
   input wire clear_i,
   input wire pwm_on_i,
   input wire scb_i,
   input wire scg_i,
   input wire ol_i,
   input wire ot_i,
   output reg drive_o,
   output reg [1:0] code_o,
   output reg ot_flag_o,
   output reg limiting_o
);
   reg [CW-1:0] filt_ff;
   reg [CW-1:0] ovl_ff;
   reg [1:0] seen_ff;
   reg off_ff;
   reg prev_cmd_ff;
   reg [1:0] cond;
   reg cond_v;
   reg thermal;
   wire fault_off;
   always @* begin
      cond = `LSW_CODE_OK;
      cond_v = 1'b0;
      if (cmd_on_i) begin
         // Faults seen on an on-switch only while it is on
         if (ot_i) begin
            cond = `LSW_CODE_OT;
            cond_v = 1'b1;
         end else if (scb_i) begin
            cond = `LSW_CODE_SCB;
            cond_v = 1'b1;
         end
      end else begin
         if (scg_i) begin
            cond = `LSW_CODE_SCG;
            cond_v = 1'b1;
         end else if (ol_i) begin
            cond = `LSW_CODE_OL;
            cond_v = 1'b1;
         end
      end
   end
   // Thermal restart only for a static-limited channel
   always @* begin
      thermal = static_lim_i & cmd_on_i & ot_i & ~off_ff;
   end
   assign fault_off = off_ff;
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         filt_ff <= {CW{1'b0}};
         ovl_ff <= {CW{1'b0}};
         seen_ff <= `LSW_CODE_OK;
         off_ff <= 1'b0;
         prev_cmd_ff <= 1'b0;
         code_o <= `LSW_CODE_OK;
         ot_flag_o <= 1'b0;
         drive_o <= 1'b0;
         limiting_o <= 1'b0;
      end else begin
         prev_cmd_ff <= cmd_on_i;
         // Filter restarts if the condition changes or vanishes
         // Cleared while stores are blocked, so a lasting fault still lands later
         if (!cond_v || cond != seen_ff || !store_en_i) begin
            filt_ff <= {CW{1'b0}};
            seen_ff <= cond;
         end else if (filt_ff != FILT_CYC[CW-1:0]) begin
            filt_ff <= filt_ff + {{(CW-1){1'b0}}, 1'b1};
         end
         // Latest filtered fault overwrites the stored code
         if (cond_v && cond == seen_ff && filt_ff == FILT_CYC[CW-1:0] - 1'b1 && store_en_i) begin
            code_o <= cond;
            if (cond == `LSW_CODE_OT && ot_i && cmd_on_i)
               ot_flag_o <= 1'b1;
         end else if (clear_i) begin
            code_o <= `LSW_CODE_OK;
            ot_flag_o <= 1'b0;
         end
         // Overload delay counter with current limit active
         if (cmd_on_i && scb_i && !off_ff) begin
            limiting_o <= 1'b1;
            if (ovl_ff != OVL_CYC[CW-1:0])
               ovl_ff <= ovl_ff + {{(CW-1){1'b0}}, 1'b1};
         end else begin
            limiting_o <= 1'b0;
            ovl_ff <= {CW{1'b0}};
         end
         // At or past the delay: leaving static mode mid-overload still trips
         if (cmd_on_i && scb_i && ovl_ff >= OVL_CYC[CW-1:0] - 1'b1 && !static_lim_i) begin
            off_ff <= 1'b1;
         end else if (clear_i || (cmd_on_i && !prev_cmd_ff)) begin
            off_ff <= 1'b0;
         end
         // Static limit stays on; thermal case pulses at low duty
         if (thermal)
            drive_o <= pwm_on_i;
         else
            drive_o <= cmd_on_i & ~fault_off;
      end
   end
endmodule
`default_nettype wire

// >>> lsw_consts.vh
// Shared constants for the low-side switch control and diagnostic block
`ifndef LSW_CONSTS_VH
`define LSW_CONSTS_VH
`define LSW_NCH 18
`define LSW_INV_CH 7
`define LSW_SRC_PIN 2'h0
`define LSW_SRC_FSB 2'h1
`define LSW_SRC_SPI 2'h2
`define LSW_CODE_OK 2'h3
`define LSW_CODE_SCB 2'h2
`define LSW_CODE_OT 2'h2
`define LSW_CODE_OL 2'h1
`define LSW_CODE_SCG 2'h0
`define LSW_FILT_NS 10000
`define LSW_FILT_CYC ((`LSW_FILT_NS + 9) / 10)
`define LSW_OVL_NS 20000
`define LSW_OVL_CYC ((`LSW_OVL_NS + 9) / 10)
`define LSW_PWM_PERIOD 100
`define LSW_PWM_ON 5
`define LSW_PIN_MASK 18'h0_FFFF
`define LSW_FSB_MASK 18'h0_FF7F
`define LSW_SCL_MASK 18'h3_C300
`endif

// >>> lsw_ctrl_diag.v
// Control source selection, supply lockout and central diagnostics
`timescale 1ns/1ps
`default_nettype none
`include "lsw_consts.vh"
module lsw_ctrl_diag #(
   parameter NCH = `LSW_NCH,
   parameter FILT_CYC = `LSW_FILT_CYC,
   parameter OVL_CYC = `LSW_OVL_CYC,
   parameter PWM_PERIOD = `LSW_PWM_PERIOD,
   parameter PWM_ON = `LSW_PWM_ON
) (
   input wire core_clk_i,
   input wire rst_i,
   input wire reset_pin_n_i,
   input wire [15:0] par_in_i,
   input wire [NCH-1:0] fsb_cmd_i,
   input wire fsb_load_i,
   input wire [NCH-1:0] spi_cmd_i,
   input wire [2*NCH-1:0] src_sel_i,
   input wire [NCH-1:0] static_lim_i,
   input wire clear_diag_i,
   input wire supply_fault_pin_i,
   input wire over_voltage_i,
   input wire inv_threshold_ok_i,
   input wire supply_low_i,
   input wire [NCH-1:0] short_to_battery_i,
   input wire [NCH-1:0] short_to_ground_i,
   input wire [NCH-1:0] open_load_i,
   input wire [NCH-1:0] over_temperature_i,
   output reg [NCH-1:0] stage_on_o,
   output reg [2*NCH-1:0] fault_code_o,
   output reg over_temp_any_o,
   output reg fault_any_o,
   output reg [15:0] read_input_status_cmd_o,
   output reg [NCH-1:0] limiting_o,
   output reg [NCH-1:0] fsb_reg_o
);
   localparam INV = `LSW_INV_CH;
   localparam [NCH-1:0] PIN_OK = `LSW_PIN_MASK;
   localparam [NCH-1:0] FSB_OK = `LSW_FSB_MASK;
   localparam [NCH-1:0] SCL_OK = `LSW_SCL_MASK;
   localparam [1:0] ST_RUN = 2'h0;
   localparam [1:0] ST_HOLD = 2'h1;

   wire [15:0] pin_s;
   wire rst_pin_n_s;
   wire sup_fault_n_s;
   wire [NCH-1:0] drive;
   wire [2*NCH-1:0] code;
   wire [NCH-1:0] otf;
   wire [NCH-1:0] lim;
   reg [NCH-1:0] cmd;
   reg [NCH-1:0] src_pin;
   reg [1:0] st_ff;
   reg [1:0] nxt_st;
   reg [7:0] pwm_ff;
   reg pwm_on;
   reg store_en;
   reg any_fault;
   reg inv_pin_mode;
   reg pin_lock;
   reg sup_lock;
   integer k;

   // Pins pass two flops before use
   lsw_sync2 #(.W(16), .INIT(16'h0000)) u_sync_pin (
      .core_clk_i(core_clk_i),
      .async_i(par_in_i),
      .sync_o(pin_s)
   );
   lsw_sync2 #(.W(2), .INIT(2'h3)) u_sync_rst (
      .core_clk_i(core_clk_i),
      .async_i({reset_pin_n_i, supply_fault_pin_i}),
      .sync_o({rst_pin_n_s, sup_fault_n_s})
   );

   // Reset pin held low acts as hold state
   always @* begin
      case (st_ff)
         ST_RUN: nxt_st = rst_pin_n_s ? ST_RUN : ST_HOLD;
         ST_HOLD: nxt_st = rst_pin_n_s ? ST_RUN : ST_HOLD;
         default: nxt_st = ST_RUN;
      endcase
   end
   always @(posedge core_clk_i) begin
      if (rst_i)
         st_ff <= ST_RUN;
      else
         st_ff <= nxt_st;
   end

   // Low duty restart pattern shared by all channels
   always @(posedge core_clk_i) begin
      if (rst_i)
         pwm_ff <= 8'h00;
      else if (pwm_ff == PWM_PERIOD[7:0] - 8'h01)
         pwm_ff <= 8'h00;
      else
         pwm_ff <= pwm_ff + 8'h01;
   end
   always @* begin
      pwm_on = (pwm_ff < PWM_ON[7:0]);
   end

   // Fast bus latch cleared by the reset pin
   always @(posedge core_clk_i) begin
      if (rst_i || st_ff == ST_HOLD)
         fsb_reg_o <= {NCH{1'b0}};
      else if (fsb_load_i)
         fsb_reg_o <= fsb_cmd_i & FSB_OK;
   end

   // Command source per channel
   always @* begin
      cmd = {NCH{1'b0}};
      src_pin = {NCH{1'b0}};
      for (k = 0; k < NCH; k = k + 1) begin
         if (src_sel_i[2*k +: 2] == `LSW_SRC_PIN && PIN_OK[k]) begin
            src_pin[k] = 1'b1;
            cmd[k] = pin_s[k];
         end else if (src_sel_i[2*k +: 2] == `LSW_SRC_FSB && FSB_OK[k]) begin
            cmd[k] = fsb_reg_o[k];
         end else begin
            cmd[k] = spi_cmd_i[k];
         end
      end
      // Inverting stage: pin-controlled in source code 0, else SPI
      // Pin high means on, so no inversion of its drive sense
      if (src_sel_i[2*INV +: 2] == `LSW_SRC_PIN) begin
         src_pin[INV] = 1'b1;
         cmd[INV] = pin_s[INV];
      end else begin
         src_pin[INV] = 1'b0;
         cmd[INV] = spi_cmd_i[INV];
      end
   end

   // Fault store gated while supply is below the reset level
   always @* begin
      store_en = ~supply_low_i & (st_ff == ST_RUN);
      inv_pin_mode = src_pin[INV];
      pin_lock = over_voltage_i | ~inv_threshold_ok_i;
      sup_lock = ~sup_fault_n_s;
   end

   // Per-channel diagnostics; source select reset value is pin mode
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         lsw_chan_diag #(
            .FILT_CYC(FILT_CYC),
            .OVL_CYC(OVL_CYC),
            .CW(16)
         ) u_ch (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .cmd_on_i(cmd[g]),
            .static_lim_i(static_lim_i[g] & SCL_OK[g]),
            .store_en_i(store_en),
            .clear_i(clear_diag_i | st_ff == ST_HOLD),
            .pwm_on_i(pwm_on),
            .scb_i(short_to_battery_i[g]),
            .scg_i(short_to_ground_i[g]),
            .ol_i(open_load_i[g]),
            .ot_i(over_temperature_i[g]),
            .drive_o(drive[g]),
            .code_o(code[2*g +: 2]),
            .ot_flag_o(otf[g]),
            .limiting_o(lim[g])
         );
      end
   endgenerate

   // Central flags
   always @* begin
      any_fault = 1'b0;
      for (k = 0; k < NCH; k = k + 1)
         any_fault = any_fault | (code[2*k +: 2] != `LSW_CODE_OK);
   end

   // Output lockout and registered outputs
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         stage_on_o <= {NCH{1'b0}};
         fault_code_o <= {2*NCH{1'b1}};
         over_temp_any_o <= 1'b0;
         fault_any_o <= 1'b0;
         read_input_status_cmd_o <= 16'h0000;
         limiting_o <= {NCH{1'b0}};
      end else begin
         for (k = 0; k < NCH; k = k + 1) begin
            if (k == INV && inv_pin_mode)
               stage_on_o[k] <= drive[k] & ~pin_lock;
            else
               stage_on_o[k] <= drive[k] & ~sup_lock & (st_ff == ST_RUN);
         end
         fault_code_o <= code;
         over_temp_any_o <= |otf;
         fault_any_o <= any_fault;
         read_input_status_cmd_o <= pin_s ^ (16'h0001 << INV);
         limiting_o <= lim;
      end
   end
endmodule
`default_nettype wire

// >>> lsw_ctrl_diag_asserts.sv
// Port-level assertions for the control and diagnostic block
`timescale 1ns/1ps
`default_nettype none
module lsw_ctrl_diag_asserts (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic reset_pin_n_i,
   input wire logic [15:0] par_in_i,
   input wire logic [17:0] spi_cmd_i,
   input wire logic clear_diag_i,
   input wire logic supply_fault_pin_i,
   input wire logic over_voltage_i,
   input wire logic supply_low_i,
   input wire logic [17:0] short_to_battery_i,
   input wire logic [17:0] short_to_ground_i,
   input wire logic [17:0] open_load_i,
   input wire logic [17:0] over_temperature_i,
   input wire logic [17:0] stage_on_o,
   input wire logic [35:0] fault_code_o,
   input wire logic fault_any_o,
   input wire logic [15:0] read_input_status_cmd_o,
   input wire logic [17:0] fsb_reg_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence ol_steady;
      (open_load_i[1] && !short_to_ground_i[1] && !stage_on_o[1] && !supply_low_i
         && !clear_diag_i && reset_pin_n_i) [*8];
   endsequence
   sequence clear_quiet;
      (clear_diag_i && ~|{short_to_battery_i, short_to_ground_i, open_load_i,
         over_temperature_i}) [*3];
   endsequence
   reset_state_a:
      assert property (disable iff (1'b0) rst_i |=> stage_on_o == 18'h0_0000 && !fault_any_o)
      else $error("stages or flags not cleared by reset");
   inv_readback_a:
      assert property (!$past(rst_i) |-> read_input_status_cmd_o == ($past(par_in_i, 3) ^ 16'h0080))
      else $error("input status readback wrong");
   serial_only_a:
      assert property ((stage_on_o[17:16] & ~$past(spi_cmd_i[17:16], 2)) == 2'b00)
      else $error("serial-only stage on without SPI command");
   fsb_mask_a:
      assert property (fsb_reg_o[7] == 1'b0 && fsb_reg_o[17:16] == 2'b00)
      else $error("fast bus reached a masked stage");
   supply_lock_a:
      assert property (!supply_fault_pin_i [*4] |=> (stage_on_o & 18'h3_FF7F) == 18'h0_0000)
      else $error("stage on during supply fault");
   over_volt_a:
      assert property (over_voltage_i [*2] |=> !stage_on_o[7])
      else $error("inverting stage on at overvoltage");
   reset_pin_lock_a:
      assert property (!reset_pin_n_i [*4] |=> (stage_on_o & 18'h3_FF7F) == 18'h0_0000)
      else $error("stage on while reset pin low");
   open_load_store_a:
      assert property (ol_steady |-> ##2 fault_code_o[3:2] == 2'h1)
      else $error("filtered open load not stored");
   clear_diag_a:
      assert property (clear_quiet |=> fault_code_o == 36'hF_FFFF_FFFF && !fault_any_o)
      else $error("clear diagnostics left a fault");
endmodule
bind lsw_ctrl_diag lsw_ctrl_diag_asserts chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .reset_pin_n_i(reset_pin_n_i), .par_in_i(par_in_i), .spi_cmd_i(spi_cmd_i),
   .clear_diag_i(clear_diag_i), .supply_fault_pin_i(supply_fault_pin_i),
   .over_voltage_i(over_voltage_i), .supply_low_i(supply_low_i),
   .short_to_battery_i(short_to_battery_i), .short_to_ground_i(short_to_ground_i),
   .open_load_i(open_load_i), .over_temperature_i(over_temperature_i),
   .stage_on_o(stage_on_o), .fault_code_o(fault_code_o), .fault_any_o(fault_any_o),
   .read_input_status_cmd_o(read_input_status_cmd_o), .fsb_reg_o(fsb_reg_o));
`default_nettype wire

// >>> lsw_ctrl_diag_test.sv
// Testbench for the control and diagnostic block
`timescale 1ns/1ps
`default_nettype none
module lsw_ctrl_diag_test;
   logic core_clk_i, rst_i, rpin_n, fsb_load, sf_n, ov, thr_ok, s_low;
   logic [17:0] fsb_cmd, slim, short_to_battery, short_to_ground, ol, ot;
   logic [15:0] par;
   logic [17:0] spi;
   logic [35:0] src;
   logic clr;
   logic [17:0] stage_on_o, limiting_o, fsb_reg_o;
   logic [35:0] fault_code_o;
   logic ot_any, f_any;
   logic [15:0] ris;
   integer fails = 0;
   integer checks = 0;
   integer n = 0;
   lsw_host_model host (.core_clk_i(core_clk_i), .par_o(par), .spi_o(spi), .src_o(src),
      .clear_o(clr));
   lsw_ctrl_diag #(.FILT_CYC(4), .OVL_CYC(6)) DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .reset_pin_n_i(rpin_n), .par_in_i(par), .fsb_cmd_i(fsb_cmd), .fsb_load_i(fsb_load),
      .spi_cmd_i(spi), .src_sel_i(src), .static_lim_i(slim), .clear_diag_i(clr),
      .supply_fault_pin_i(sf_n), .over_voltage_i(ov), .inv_threshold_ok_i(thr_ok),
      .supply_low_i(s_low), .short_to_battery_i(short_to_battery), .short_to_ground_i(short_to_ground),
      .open_load_i(ol), .over_temperature_i(ot), .stage_on_o(stage_on_o),
      .fault_code_o(fault_code_o), .over_temp_any_o(ot_any), .fault_any_o(f_any),
      .read_input_status_cmd_o(ris), .limiting_o(limiting_o), .fsb_reg_o(fsb_reg_o));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task step(input integer n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // Bounded wait on the masked gate drives, then compare
   task wt(input logic [17:0] m, input logic [17:0] v);
      integer i;
      for (i = 0; i < 40 && (stage_on_o & m) !== v; i++) step(1);
      chk(stage_on_o & m, v);
      if (i == 40) give_verdict();
   endtask
   initial begin
      rst_i = 1'b1; rpin_n = 1'b1; fsb_load = 1'b0; sf_n = 1'b1; ov = 1'b0;
      thr_ok = 1'b1; s_low = 1'b0; fsb_cmd = 18'h0_0000; slim = 18'h0_0000;
      short_to_battery = 18'h0_0000; short_to_ground = 18'h0_0000; ol = 18'h0_0000; ot = 18'h0_0000;
      step(4);
      rst_i = 1'b0;
      host.set_ctl(16'h0081, 18'h0_0000, 36'h0_0000_0000);
      wt(18'h3_FFFF, 18'h0_0081);
      chk(ris, 16'h0001);
      rpin_n = 1'b0;
      wt(18'h3_FFFF, 18'h0_0080);
      rpin_n = 1'b1;
      sf_n = 1'b0;
      step(6);
      wt(18'h3_FFFF, 18'h0_0080);
      sf_n = 1'b1;
      ov = 1'b1;
      wt(18'h3_FFFF, 18'h0_0001);
      ov = 1'b0;
      thr_ok = 1'b0;
      step(4);
      wt(18'h3_FFFF, 18'h0_0001);
      thr_ok = 1'b1;
      wt(18'h3_FFFF, 18'h0_0081);
      short_to_battery = 18'h0_0001;
      wt(18'h3_FFFF, 18'h0_0080);
      chk(fault_code_o[1:0], 2'h2);
      chk(f_any, 1'b1);
      short_to_battery = 18'h0_0000;
      host.clear_diag();
      wt(18'h3_FFFF, 18'h0_0081);
      chk(fault_code_o, 36'hF_FFFF_FFFF);
      ot = 18'h0_0001;
      step(10);
      chk(ot_any, 1'b1);
      ot = 18'h0_0000;
      host.clear_diag();
      host.set_ctl(16'h0181, 18'h0_0000, 36'h0_0000_0000);
      slim = 18'h0_0100;
      short_to_battery = 18'h0_0100;
      step(20);
      chk({stage_on_o[8], limiting_o[8], fault_code_o[17:16]}, 4'hE);
      ot = 18'h0_0100;
      step(3);
      n = 0;
      repeat (100) begin
         step(1);
         n = n + stage_on_o[8];
      end
      chk(n, 5);
      ot = 18'h0_0000;
      slim = 18'h0_0000;
      wt(18'h0_0100, 18'h0_0000);
      short_to_battery = 18'h0_0000;
      s_low = 1'b1;
      ol = 18'h0_0002;
      step(12);
      chk(fault_code_o[3:2], 2'h3);
      s_low = 1'b0;
      step(12);
      chk(fault_code_o[3:2], 2'h1);
      ol = 18'h0_0000;
      rpin_n = 1'b0;
      step(6);
      chk(fault_code_o[3:2], 2'h3);
      rpin_n = 1'b1;
      host.set_ctl(16'hFFFF, 18'h3_0000, 36'hA_AAAA_AAAA);
      wt(18'h3_FFFF, 18'h3_0000);
      host.set_ctl(16'h0000, 18'h0_0000, 36'h5_5555_5555);
      fsb_cmd = 18'h3_FFFF;
      fsb_load = 1'b1;
      step(1);
      fsb_load = 1'b0;
      wt(18'h3_FFFF, 18'h0_FF7F);
      chk(fsb_reg_o, 18'h0_FF7F);
      give_verdict();
   end
endmodule
`default_nettype wire

// >>> lsw_host_model.sv
// Host model: parallel pins, SPI command bits, source select, clear
`timescale 1ns/1ps
`default_nettype none
module lsw_host_model (
   input wire logic core_clk_i,
   output logic [15:0] par_o,
   output logic [17:0] spi_o,
   output logic [35:0] src_o,
   output logic clear_o
);
   initial begin
      par_o = 16'h0000;
      spi_o = 18'h0_0000;
      src_o = 36'h0_0000_0000;
      clear_o = 1'b0;
   end
   task set_ctl(input logic [15:0] par, input logic [17:0] spi, input logic [35:0] src);
      @(posedge core_clk_i);
      #1;
      par_o = par;
      spi_o = spi;
      src_o = src;
   endtask
   // Held three cycles, the length of the clear_quiet sequence in the assertions
   task clear_diag();
      @(posedge core_clk_i);
      #1;
      clear_o = 1'b1;
      repeat (3) @(posedge core_clk_i);
      #1;
      clear_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> lsw_sync2.v
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module lsw_sync2 #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire core_clk_i,
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   reg [W-1:0] s1_ff;
   reg [W-1:0] s2_ff;
   initial begin
      s1_ff = INIT;
      s2_ff = INIT;
   end
   // No reset: the reset pin itself passes through here
   always @(posedge core_clk_i) begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
   end
   assign sync_o = s2_ff;
endmodule
`default_nettype wire
